// >>> slat_pkg.sv
/*
 * slat_pkg: register map, field positions, state codes and timing
 * constants of the speed-loop inertia auto-tune sequencer.
 * Assumes a 50 MHz system clock and an AHB-Lite register bus.
 */
`default_nettype none
package slat_pkg;
	// clock and time base
	localparam int CLK_PERIOD_NS = 20;
	localparam int TICK_NS = 1_000_000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam int DWELL_MS = 500;
	localparam int MINUTE_MS = 60_000;
	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CMD = 8'h04;
	localparam logic [7:0] ADDR_TORQUE = 8'h08;
	localparam logic [7:0] ADDR_SPEED = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_INERTIA = 8'h14;
	localparam logic [7:0] ADDR_BW = 8'h18;
	localparam logic [7:0] ADDR_KI = 8'h1C;
	localparam logic [7:0] ADDR_KP = 8'h20;
	localparam logic [7:0] ADDR_KF = 8'h24;
	localparam logic [7:0] ADDR_FILT = 8'h28;
	localparam logic [7:0] ADDR_RATE = 8'h2C;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h30;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h34;
	// field positions
	localparam int CTRL_TUNE_SEL_BIT = 5;
	localparam int CTRL_BRAKE_BIT = 10;
	localparam int CMD_START_BIT = 0;
	localparam int CMD_STOP_BIT = 1;
	localparam int ST_EXEC = 0;
	localparam int ST_DONE = 1;
	localparam int ST_ERROR = 2;
	localparam int ST_ABORT = 3;
	localparam int ST_FLUX = 4;
	localparam int ST_NOT_READY = 5;
	localparam int ST_NOT_ZERO = 6;
	localparam int ST_RUNNING = 7;
	localparam int ST_TIMEOUT = 12;
	localparam int ST_NO_TLIM = 13;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ERROR = 1;
	localparam int IRQ_ABORT = 2;
	localparam int STATE_LSB = 16;
	// reset values and calculation constants
	localparam logic [15:0] RST_TORQUE = 16'h0000;
	localparam logic [15:0] RST_SPEED = 16'h0000;
	localparam logic [15:0] RST_BW = 16'h000A;
	localparam logic [15:0] KF_VALUE = 16'h0000;
	localparam logic [15:0] FILT_SEL_VALUE = 16'h0001;
	localparam logic [15:0] ERR_BW_MULT = 16'h0005;
	localparam logic [15:0] RATE_LIM_VALUE = 16'h0FA0;
	localparam logic [15:0] SPEED_FRACTION = 16'h0014;
	localparam int INERTIA_SHIFT = 8;
	localparam int GAIN_SHIFT = 8;
	typedef enum logic [2:0] {
		ST_WAIT = 3'b000,
		ST_START = 3'b001,
		ST_DWELL = 3'b010,
		ST_MEASURE = 3'b011,
		ST_STOP = 3'b100
	} slat_state_t;
endpackage : slat_pkg
`default_nettype wire

// >>> slat_autotune.sv
/*
 * slat_autotune: speed-loop inertia auto-tune sequencer with an AHB-Lite
 * register slave, read-clear interrupt status and drive-side outputs.
 * Assumes drive condition and speed feedback inputs are asynchronous
 * and a single 50 MHz clock; speed feedback is an unsigned magnitude.
 */
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module slat_autotune #(
	parameter int TICK_CYCLES = slat_pkg::TICK_CYCLES,
	parameter int DWELL_MS = slat_pkg::DWELL_MS,
	parameter int MINUTE_MS = slat_pkg::MINUTE_MS
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// drive and motor side
	input wire logic [15:0] speed_fb,
	input wire logic flux_active,
	input wire logic drive_ready,
	input wire logic at_zero_speed,
	input wire logic motor_running,
	input wire logic torque_limit,
	output logic signed [15:0] torque_cmd,
	output logic [15:0] speed_ref,
	output logic tune_active,
	// interrupt
	output logic irq
);
	// two-stage synchronisers
	logic [15:0] spd_s1_r, spd_r;
	logic [4:0] cond_s1_r, cond_r;
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			spd_s1_r <= 16'h0000;
			spd_r <= 16'h0000;
			cond_s1_r <= 5'h00;
			cond_r <= 5'h00;
		end else begin
			spd_s1_r <= speed_fb;
			spd_r <= spd_s1_r;
			cond_s1_r <= {torque_limit, motor_running, at_zero_speed, drive_ready, flux_active};
			cond_r <= cond_s1_r;
		end
	end
	wire logic flux_q = cond_r[0];
	wire logic ready_q = cond_r[1];
	wire logic zero_q = cond_r[2];
	wire logic run_q = cond_r[3];
	wire logic tlim_q = cond_r[4];
	// bus address phase capture; zero wait states
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	wire logic addr_ok = hsel & htrans[1] & hready;
	wire logic rd_take = addr_ok & ~hwrite;
	wire logic wr_now = wr_pend_r;
	wire logic cmd_wr = wr_now & (wr_addr_r == slat_pkg::ADDR_CMD);
	wire logic start_cmd = cmd_wr & hwdata[slat_pkg::CMD_START_BIT];
	wire logic stop_cmd = cmd_wr & hwdata[slat_pkg::CMD_STOP_BIT];
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			wr_pend_r <= addr_ok & hwrite;
			wr_addr_r <= haddr[7:0];
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end
	// software settings
	logic [31:0] ctrl_r;
	logic [15:0] torque_set_r, speed_set_r, bw_r;
	logic [2:0] irq_mask_r;
	slat_pkg::slat_state_t state_r;
	wire logic leave_wait = (state_r == slat_pkg::ST_WAIT) & ctrl_r[slat_pkg::CTRL_TUNE_SEL_BIT];
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			ctrl_r <= 32'h0000_0000;
			torque_set_r <= slat_pkg::RST_TORQUE;
			speed_set_r <= slat_pkg::RST_SPEED;
			bw_r <= slat_pkg::RST_BW;
			irq_mask_r <= 3'h0;
		end else begin
			if (wr_now && wr_addr_r == slat_pkg::ADDR_CTRL)
				ctrl_r <= hwdata;
			// select bit self-clears once taken so a finished test does not rerun
			if (leave_wait)
				ctrl_r[slat_pkg::CTRL_TUNE_SEL_BIT] <= 1'b0;
			if (wr_now && wr_addr_r == slat_pkg::ADDR_TORQUE)
				torque_set_r <= hwdata[15:0];
			if (wr_now && wr_addr_r == slat_pkg::ADDR_SPEED)
				speed_set_r <= hwdata[15:0];
			if (wr_now && wr_addr_r == slat_pkg::ADDR_BW)
				bw_r <= hwdata[15:0];
			if (wr_now && wr_addr_r == slat_pkg::ADDR_IRQ_MASK)
				irq_mask_r <= hwdata[2:0];
		end
	end
	wire logic brake_en = ctrl_r[slat_pkg::CTRL_BRAKE_BIT];
	// millisecond tick
	logic [31:0] tick_cnt_r;
	wire logic tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));
	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			tick_cnt_r <= 32'h0000_0000;
		else
			tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
	end
	// sequencer
	logic falling_r, tlim_seen_r;
	logic [15:0] ms_cnt_r, rise_ms_r, fall_ms_r, speed_mark_r;
	logic [15:0] status_r;
	logic calc_r;
	wire logic active = (state_r == slat_pkg::ST_DWELL) | (state_r == slat_pkg::ST_MEASURE);
	wire logic abort_ev = stop_cmd & (active | state_r == slat_pkg::ST_START);
	wire logic [3:0] cause = {run_q, ~zero_q, ~ready_q, flux_q};
	wire logic start_err = (state_r == slat_pkg::ST_START) & start_cmd & ~stop_cmd & (|cause);
	wire logic dwell_done = tick & (ms_cnt_r == 16'(DWELL_MS - 1));
	wire logic at_speed = ~falling_r & (spd_r >= speed_set_r);
	wire logic at_stand = falling_r & (spd_r == 16'h0000);
	wire logic minute_end = tick & (ms_cnt_r == 16'(MINUTE_MS - 1));
	wire logic [15:0] min_gain = speed_set_r / slat_pkg::SPEED_FRACTION;
	wire logic timeout_ev = (state_r == slat_pkg::ST_MEASURE) & ~falling_r & minute_end & ~at_speed
		& ((spd_r - speed_mark_r) < min_gain);
	wire logic measure_end = (state_r == slat_pkg::ST_MEASURE) & at_stand & ~stop_cmd;
	wire logic no_tlim_ev = measure_end & ~tlim_seen_r;
	wire logic done_ev = measure_end & tlim_seen_r;
	wire logic err_ev = start_err | timeout_ev | no_tlim_ev;
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state_r <= slat_pkg::ST_WAIT;
		end else begin
			case (state_r)
				slat_pkg::ST_WAIT: if (leave_wait) state_r <= slat_pkg::ST_START;
				slat_pkg::ST_START: begin
					if (stop_cmd)
						state_r <= slat_pkg::ST_WAIT;
					else if (start_err)
						state_r <= slat_pkg::ST_STOP;
					else if (start_cmd)
						state_r <= slat_pkg::ST_DWELL;
				end
				slat_pkg::ST_DWELL: begin
					if (stop_cmd)
						state_r <= slat_pkg::ST_STOP;
					else if (dwell_done)
						state_r <= slat_pkg::ST_MEASURE;
				end
				slat_pkg::ST_MEASURE: begin
					if (stop_cmd || timeout_ev || measure_end)
						state_r <= slat_pkg::ST_STOP;
				end
				slat_pkg::ST_STOP: state_r <= slat_pkg::ST_WAIT;
				default: state_r <= slat_pkg::ST_WAIT;
			endcase
		end
	end
	// timers and slope capture
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			ms_cnt_r <= 16'h0000;
			rise_ms_r <= 16'h0000;
			fall_ms_r <= 16'h0000;
			falling_r <= 1'b0;
			speed_mark_r <= 16'h0000;
			tlim_seen_r <= 1'b0;
		end else if (state_r == slat_pkg::ST_DWELL) begin
			if (dwell_done)
				ms_cnt_r <= 16'h0000;
			else if (tick)
				ms_cnt_r <= ms_cnt_r + 16'h0001;
			rise_ms_r <= 16'h0000;
			fall_ms_r <= 16'h0000;
			falling_r <= 1'b0;
			speed_mark_r <= spd_r;
			tlim_seen_r <= 1'b0;
		end else if (state_r == slat_pkg::ST_MEASURE) begin
			if (tlim_q)
				tlim_seen_r <= 1'b1;
			// rise and fall times give the slopes
			if (at_speed)
				falling_r <= 1'b1;
			if (tick && !falling_r && !at_speed)
				rise_ms_r <= rise_ms_r + 16'h0001;
			if (tick && falling_r && fall_ms_r != 16'hFFFF)
				fall_ms_r <= fall_ms_r + 16'h0001;
			if (minute_end) begin
				ms_cnt_r <= 16'h0000;
				speed_mark_r <= spd_r;
			end else if (tick) begin
				ms_cnt_r <= ms_cnt_r + 16'h0001;
			end
		end else begin
			ms_cnt_r <= 16'h0000;
		end
	end
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			torque_cmd <= 16'sh0000;
			speed_ref <= 16'h0000;
			tune_active <= 1'b0;
		end else if (state_r == slat_pkg::ST_MEASURE && !stop_cmd && !timeout_ev && !at_stand) begin
			tune_active <= 1'b1;
			if (!falling_r && !at_speed) begin
				torque_cmd <= $signed(torque_set_r);
				speed_ref <= speed_set_r;
			end else if (brake_en) begin
				torque_cmd <= -$signed(torque_set_r);
				if (tick)
					speed_ref <= (spd_r < speed_ref) ? spd_r : speed_ref;
			end else begin
				torque_cmd <= 16'sh0000;
				speed_ref <= 16'h0000;
			end
		end else begin
			torque_cmd <= 16'sh0000;
			speed_ref <= 16'h0000;
			tune_active <= (state_r == slat_pkg::ST_DWELL) & ~stop_cmd & ~dwell_done;
		end
	end
	// inertia result latched at measure end, gain results computed in stop state
	logic [15:0] inertia_r, ki_r, kp_r, err_bw_r, filt_sel_r, rate_r;
	wire logic [15:0] slope_ms = brake_en ? 16'((17'(rise_ms_r) + 17'(fall_ms_r)) >> 1) : rise_ms_r;
	wire logic [31:0] inertia_prod = torque_set_r * slope_ms;
	wire logic [31:0] kp_prod = bw_r * inertia_r;
	wire logic [31:0] ki_prod = bw_r * kp_prod[slat_pkg::GAIN_SHIFT +: 16];
	wire logic [31:0] ebw_prod = bw_r * slat_pkg::ERR_BW_MULT;
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			calc_r <= 1'b0;
			inertia_r <= 16'h0000;
			kp_r <= 16'h0000;
			ki_r <= 16'h0000;
			err_bw_r <= 16'h0000;
			filt_sel_r <= 16'h0000;
			rate_r <= 16'h0000;
		end else begin
			calc_r <= done_ev;
			if (done_ev)
				inertia_r <= inertia_prod[slat_pkg::INERTIA_SHIFT +: 16];
			if (calc_r) begin
				kp_r <= kp_prod[slat_pkg::GAIN_SHIFT +: 16];
				ki_r <= ki_prod[slat_pkg::GAIN_SHIFT +: 16];
				err_bw_r <= ebw_prod[15:0];
				filt_sel_r <= slat_pkg::FILT_SEL_VALUE;
				rate_r <= slat_pkg::RATE_LIM_VALUE;
			end
		end
	end
	// tuning status word
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			status_r <= 16'h0000;
		end else if (leave_wait) begin
			status_r <= 16'h0000;
		end else begin
			status_r[slat_pkg::ST_EXEC] <= (state_r == slat_pkg::ST_DWELL && !stop_cmd)
				|| (state_r == slat_pkg::ST_START && start_cmd && !stop_cmd && !start_err)
				|| (state_r == slat_pkg::ST_MEASURE && !stop_cmd && !timeout_ev && !measure_end);
			if (calc_r)
				status_r[slat_pkg::ST_DONE] <= 1'b1;
			if (abort_ev)
				status_r[slat_pkg::ST_ABORT] <= 1'b1;
			if (err_ev)
				status_r[slat_pkg::ST_ERROR] <= 1'b1;
			if (start_err) begin
				status_r[slat_pkg::ST_FLUX] <= cause[0];
				status_r[slat_pkg::ST_NOT_READY] <= cause[1];
				status_r[slat_pkg::ST_NOT_ZERO] <= cause[2];
				status_r[slat_pkg::ST_RUNNING] <= cause[3];
			end
			if (timeout_ev)
				status_r[slat_pkg::ST_TIMEOUT] <= 1'b1;
			if (no_tlim_ev)
				status_r[slat_pkg::ST_NO_TLIM] <= 1'b1;
		end
	end
	// interrupt status: read clears, new event wins
	logic [2:0] irq_stat_r;
	wire logic [2:0] irq_ev = {abort_ev, err_ev, calc_r};
	wire logic irq_rd = rd_take & (haddr[7:0] == slat_pkg::ADDR_IRQ_STAT);
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			irq_stat_r <= 3'h0;
			irq <= 1'b0;
		end else begin
			irq_stat_r <= (irq_rd ? 3'h0 : irq_stat_r) | irq_ev;
			irq <= |(irq_stat_r & irq_mask_r);
		end
	end
	// read data registered at address phase
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_take) begin
			case (haddr[7:0])
				slat_pkg::ADDR_CTRL: hrdata <= ctrl_r;
				slat_pkg::ADDR_TORQUE: hrdata <= {16'h0000, torque_set_r};
				slat_pkg::ADDR_SPEED: hrdata <= {16'h0000, speed_set_r};
				slat_pkg::ADDR_STATUS: hrdata <= {13'h0000, state_r, status_r};
				slat_pkg::ADDR_INERTIA: hrdata <= {16'h0000, inertia_r};
				slat_pkg::ADDR_BW: hrdata <= {16'h0000, bw_r};
				slat_pkg::ADDR_KI: hrdata <= {16'h0000, ki_r};
				slat_pkg::ADDR_KP: hrdata <= {16'h0000, kp_r};
				slat_pkg::ADDR_KF: hrdata <= {16'h0000, slat_pkg::KF_VALUE};
				slat_pkg::ADDR_FILT: hrdata <= {err_bw_r, filt_sel_r};
				slat_pkg::ADDR_RATE: hrdata <= {16'h0000, rate_r};
				slat_pkg::ADDR_IRQ_STAT: hrdata <= {29'h0000_0000, irq_stat_r};
				slat_pkg::ADDR_IRQ_MASK: hrdata <= {29'h0000_0000, irq_mask_r};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end
	a_state_range: assert property (@(posedge clock) disable iff (reset) state_r <= slat_pkg::ST_STOP)
		else $error("state code out of range");
	a_wait_idle: assert property (@(posedge clock) disable iff (reset)
		(state_r == slat_pkg::ST_WAIT && !ctrl_r[slat_pkg::CTRL_TUNE_SEL_BIT])
		|=> state_r == slat_pkg::ST_WAIT) else $error("left wait without select");
	a_start_hold: assert property (@(posedge clock) disable iff (reset)
		(state_r == slat_pkg::ST_START && !start_cmd && !stop_cmd)
		|=> state_r == slat_pkg::ST_START) else $error("left start without command");
	a_dwell_hold: assert property (@(posedge clock) disable iff (reset)
		(state_r == slat_pkg::ST_DWELL && !dwell_done && !stop_cmd)
		|=> state_r == slat_pkg::ST_DWELL) else $error("dwell ended early");
	a_rise_torque: assert property (@(posedge clock) disable iff (reset)
		(state_r == slat_pkg::ST_MEASURE && !falling_r && !at_speed && !stop_cmd && !timeout_ev)
		|=> torque_cmd == $signed($past(torque_set_r))) else $error("tuning torque not applied");
	a_brake_torque: assert property (@(posedge clock) disable iff (reset)
		(state_r == slat_pkg::ST_MEASURE && falling_r && brake_en && !at_stand && !stop_cmd)
		|=> torque_cmd == -$signed($past(torque_set_r))) else $error("brake torque missing");
	a_coast_torque: assert property (@(posedge clock) disable iff (reset)
		(state_r == slat_pkg::ST_MEASURE && falling_r && !brake_en)
		|=> torque_cmd == 16'sh0000) else $error("coast torque not zero");
	a_abort_flag: assert property (@(posedge clock) disable iff (reset)
		abort_ev |=> status_r[slat_pkg::ST_ABORT] ##1 state_r == slat_pkg::ST_WAIT)
		else $error("abort not flagged");
	a_cause_error: assert property (@(posedge clock) disable iff (reset)
		start_err |=> status_r[slat_pkg::ST_ERROR] && status_r[7:4] == $past(cause))
		else $error("error cause wrong");
	a_timeout_flag: assert property (@(posedge clock) disable iff (reset)
		timeout_ev |=> status_r[slat_pkg::ST_TIMEOUT] && status_r[slat_pkg::ST_ERROR])
		else $error("timeout not flagged");
	a_no_tlim: assert property (@(posedge clock) disable iff (reset)
		no_tlim_ev |=> status_r[slat_pkg::ST_NO_TLIM] && !status_r[slat_pkg::ST_DONE])
		else $error("torque limit cause missing");
	a_done_gains: assert property (@(posedge clock) disable iff (reset)
		done_ev |=> calc_r ##1 (status_r[slat_pkg::ST_DONE] && rate_r == slat_pkg::RATE_LIM_VALUE))
		else $error("gains not written");
	a_irq_level: assert property (@(posedge clock) disable iff (reset)
		##1 irq == |($past(irq_stat_r) & $past(irq_mask_r))) else $error("interrupt level wrong");
endmodule : slat_autotune
`default_nettype wire

// >>> slat_motor.sv
/*
 * slat_motor: behavioural motor and load on the drive side of the
 * auto-tune sequencer, with knobs for start faults, stall and torque limit.
 * Assumes the bench drives the knobs right after a rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module slat_motor (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// from the drive
	input wire logic signed [15:0] torque_cmd,
	// bench knobs
	input wire logic [3:0] cause,
	input wire logic stall,
	input wire logic [15:0] lim,
	// feedback to the drive
	output logic [15:0] speed_fb,
	output logic flux_active,
	output logic drive_ready,
	output logic at_zero_speed,
	output logic motor_running,
	output logic torque_limit
);
	logic [1:0] pre_r;
	// speed moves every fourth cycle so the synchronisers see steady values
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			pre_r <= 2'h0;
			speed_fb <= 16'h0000;
		end else begin
			pre_r <= pre_r + 2'h1;
			if (pre_r == 2'h3) begin
				if (!torque_cmd[15] && torque_cmd != 16'sh0000 && !stall)
					speed_fb <= speed_fb + 16'h0001;
				else if (torque_cmd[15])
					speed_fb <= (speed_fb > 16'h0001) ? speed_fb - 16'h0002 : 16'h0000;
				else if (torque_cmd == 16'sh0000 && speed_fb != 16'h0000)
					speed_fb <= speed_fb - 16'h0001;
			end
		end
	end
	assign flux_active = cause[0];
	assign drive_ready = !cause[1];
	assign at_zero_speed = (speed_fb == 16'h0000) && !cause[2];
	assign motor_running = (speed_fb != 16'h0000) || cause[3];
	// limit only seen for forward torque at or above the bench level
	assign torque_limit = !torque_cmd[15] && (torque_cmd[14:0] >= lim[14:0]);
endmodule : slat_motor
`default_nettype wire

// >>> speed_loop_inertia_autotune_tb.sv
/*
 * speed_loop_inertia_autotune_tb: AHB-Lite driven tests of the auto-tune
 * sequencer against the behavioural motor, with shortened time base.
 * Assumes a zero-wait-state slave whose hreadyout is the bus hready.
 */
`timescale 1ns/1ps
`default_nettype none
module speed_loop_inertia_autotune_tb;
	logic clock, reset, hsel, hwrite, hready, hreadyout, hresp, tune_active, irq, stall;
	logic [31:0] haddr, hwdata, hrdata, rd, ine;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] cause;
	logic [15:0] speed_fb, speed_ref, lim;
	logic signed [15:0] torque_cmd;
	logic flux_active, drive_ready, at_zero_speed, motor_running, torque_limit;
	int num_errors, n_compared, i, n;
	localparam logic [15:0] TQ = 16'h0100;
	localparam logic [15:0] SPD = 16'h0028;
	localparam logic [7:0] A_ST = slat_pkg::ADDR_STATUS;
	assign hready = hreadyout;

	slat_autotune #(.TICK_CYCLES(4), .DWELL_MS(3), .MINUTE_MS(50)) i_dut (
		.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .speed_fb(speed_fb),
		.flux_active(flux_active), .drive_ready(drive_ready),
		.at_zero_speed(at_zero_speed), .motor_running(motor_running),
		.torque_limit(torque_limit), .torque_cmd(torque_cmd), .speed_ref(speed_ref),
		.tune_active(tune_active), .irq(irq));

	slat_motor i_motor (
		.clock(clock), .reset(reset), .torque_cmd(torque_cmd), .cause(cause),
		.stall(stall), .lim(lim), .speed_fb(speed_fb), .flux_active(flux_active),
		.drive_ready(drive_ready), .at_zero_speed(at_zero_speed),
		.motor_running(motor_running), .torque_limit(torque_limit));

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// one single transfer; waits on hready in both phases
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge clock);
		while (!hreadyout) @(posedge clock);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clock);
		while (!hreadyout) @(posedge clock);
		rd = hrdata;
	endtask : bus

	// polls the state code; state 0 also waits for the motor to stand
	task automatic wait_st(input logic [2:0] s);
		n = 0;
		do begin
			bus(A_ST, 1'b0, 32'h0000_0000);
			n++;
		end while ((rd[18:16] !== s || (s == 3'h0 && speed_fb != 16'h0000)) && n < 600);
		check(32'(n < 600), 32'h0000_0001); // state reached
	endtask : wait_st

	task automatic start(input logic [31:0] ctrl);
		bus(slat_pkg::ADDR_CTRL, 1'b1, ctrl);
		bus(slat_pkg::ADDR_CMD, 1'b1, 32'h0000_0001);
	endtask : start

	task automatic finish_chk(input logic [31:0] sts, input logic [31:0] ist);
		wait_st(3'h0);
		check(rd & 32'h0000_FFFE, sts); // final flags
		bus(slat_pkg::ADDR_IRQ_STAT, 1'b0, 32'h0000_0000);
		check(rd, ist); // event bits
	endtask : finish_chk

	task automatic to_speed();
		for (n = 0; n < 800 && speed_fb < SPD; n++) @(posedge clock);
		repeat (4) @(posedge clock);
	endtask : to_speed

	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		$display("watchdog expired");
		final_report();
	end

	initial begin
		{hsel, hwrite, htrans, haddr, hwdata, stall, cause} = '0;
		reset = 1'b1;
		hsize = 3'h2;
		lim = TQ;
		num_errors = 0;
		n_compared = 0;
		repeat (4) @(posedge clock);
		reset <= 1'b0;
		repeat (2) @(posedge clock);
		bus(A_ST, 1'b0, 32'h0000_0000);
		check(rd, 32'h0000_0000); // idle at reset
		check(32'(hresp), 32'h0000_0000); // okay response
		bus(slat_pkg::ADDR_BW, 1'b0, 32'h0000_0000);
		check(rd, 32'h0000_000A); // bandwidth default
		bus(8'h40, 1'b0, 32'h0000_0000);
		check(rd, 32'h0000_0000); // unmapped reads zero
		bus(A_ST, 1'b1, 32'h0000_FFFF);
		bus(A_ST, 1'b0, 32'h0000_0000);
		check(rd, 32'h0000_0000); // read only
		bus(slat_pkg::ADDR_IRQ_MASK, 1'b1, 32'h0000_0007);
		bus(slat_pkg::ADDR_TORQUE, 1'b1, {16'h0000, TQ});
		bus(slat_pkg::ADDR_SPEED, 1'b1, {16'h0000, SPD});
		$display("test registers done");
		bus(slat_pkg::ADDR_CMD, 1'b1, 32'h0000_0001);
		bus(A_ST, 1'b0, 32'h0000_0000);
		check(32'(rd[18:16]), 32'h0000_0000); // start ignored in wait
		bus(slat_pkg::ADDR_CTRL, 1'b1, 32'h0000_0020);
		repeat (6) @(posedge clock);
		bus(A_ST, 1'b0, 32'h0000_0000);
		check(32'(rd[18:16]), 32'h0000_0001); // holds for start
		bus(slat_pkg::ADDR_CMD, 1'b1, 32'h0000_0002);
		wait_st(3'h0);
		check(32'(irq), 32'h0000_0001); // abort interrupt
		finish_chk(32'h0000_0008, 32'h0000_0004); // abort from start
		@(posedge clock);
		@(posedge clock);
		check(32'(irq), 32'h0000_0000); // cleared by read
		$display("test select and abort done");
		for (i = 0; i < 4; i++) begin
			cause <= 4'(1 << i);
			start(32'h0000_0020);
			finish_chk(32'h0000_0004 | (32'h0000_0010 << i), 32'h0000_0002);
		end
		cause <= 4'h0;
		$display("test error causes done");
		start(32'h0000_0020);
		bus(A_ST, 1'b0, 32'h0000_0000);
		check(32'(rd[18:16]), 32'h0000_0002); // dwell
		check(32'(rd[0]), 32'h0000_0001); // executing
		check(32'(tune_active), 32'h0000_0001); // active
		wait_st(3'h3);
		check({16'h0000, torque_cmd}, {16'h0000, TQ}); // torque applied
		check({16'h0000, speed_ref}, {16'h0000, SPD}); // target speed
		to_speed();
		check({16'h0000, torque_cmd}, 32'h0000_0000); // coast torque
		finish_chk(32'h0000_0002, 32'h0000_0001); // done
		repeat (20) @(posedge clock);
		bus(A_ST, 1'b0, 32'h0000_0000);
		check(rd & 32'h0007_FFFE, 32'h0000_0002); // flags kept
		bus(slat_pkg::ADDR_INERTIA, 1'b0, 32'h0000_0000);
		ine = rd;
		check(32'(ine != 32'h0000_0000), 32'h0000_0001); // inertia stored
		bus(slat_pkg::ADDR_KP, 1'b0, 32'h0000_0000);
		check(rd, ((ine * 32'h0000_000A) >> 8) & 32'h0000_FFFF); // proportional
		ine = rd;
		bus(slat_pkg::ADDR_KI, 1'b0, 32'h0000_0000);
		check(rd, ((ine * 32'h0000_000A) >> 8) & 32'h0000_FFFF); // integral
		bus(slat_pkg::ADDR_KF, 1'b0, 32'h0000_0000);
		check(rd, 32'h0000_0000); // feed forward
		bus(slat_pkg::ADDR_FILT, 1'b0, 32'h0000_0000);
		check(rd, 32'h0032_0001); // filters
		bus(slat_pkg::ADDR_RATE, 1'b0, 32'h0000_0000);
		check(rd, 32'h0000_0FA0); // rate limit
		$display("test coast run done");
		start(32'h0000_0420);
		wait_st(3'h3);
		to_speed();
		check({16'h0000, torque_cmd}, {16'h0000, 16'h0000 - TQ}); // braking
		finish_chk(32'h0000_0002, 32'h0000_0001); // done
		$display("test brake run done");
		lim <= 16'h7FFF;
		start(32'h0000_0020);
		finish_chk(32'h0000_2004, 32'h0000_0002); // no limit
		lim <= TQ;
		$display("test torque limit done");
		bus(slat_pkg::ADDR_IRQ_MASK, 1'b1, 32'h0000_0000);
		stall <= 1'b1;
		start(32'h0000_0020);
		wait_st(3'h0);
		check(32'(irq), 32'h0000_0000); // masked
		finish_chk(32'h0000_1004, 32'h0000_0002); // timeout
		stall <= 1'b0;
		bus(slat_pkg::ADDR_IRQ_MASK, 1'b1, 32'h0000_0007);
		$display("test timeout done");
		start(32'h0000_0020);
		wait_st(3'h3);
		repeat (20) @(posedge clock);
		bus(slat_pkg::ADDR_CMD, 1'b1, 32'h0000_0002);
		bus(A_ST, 1'b0, 32'h0000_0000);
		check({16'h0000, torque_cmd}, 32'h0000_0000); // outputs off
		finish_chk(32'h0000_0008, 32'h0000_0004); // abort in measure
		$display("test abort in measure done");
		start(32'h0000_0020);
		bus(slat_pkg::ADDR_CMD, 1'b1, 32'h0000_0002);
		finish_chk(32'h0000_0008, 32'h0000_0004); // abort in dwell
		$display("test abort in dwell done");
		final_report();
	end
endmodule : speed_loop_inertia_autotune_tb
`default_nettype wire
